// *** rtl/omm_defs.svh ***
`ifndef OMM_DEFS_SVH
`define OMM_DEFS_SVH

`define OMM_CLK_MHZ        100
`define OMM_T_OFF_US       10
`define OMM_T_OFF_CYC      (`OMM_T_OFF_US * `OMM_CLK_MHZ)
`define OMM_T_ON_MS        1
`define OMM_T_INIT_MS      300
`define OMM_T_INIT_CYC     (`OMM_T_INIT_MS * 1000 * `OMM_CLK_MHZ)
`define OMM_T_RESET_US     10
`define OMM_T_RESET_CYC    (`OMM_T_RESET_US * `OMM_CLK_MHZ)
`define OMM_SCL_MAX_KHZ    400

`define OMM_ADDR_ID        7'h50
`define OMM_ADDR_DIAG      7'h51
`define OMM_ID_DEPTH       16
`define OMM_NUM_QTY        5

`define OMM_DIAG_VAL_LAST  8'h09
`define OMM_DIAG_STATUS    8'h0A
`define OMM_DIAG_CAL_BASE  8'h10
`define OMM_DIAG_CAL_LAST  8'h19

`define OMM_STAT_TXOFF     0
`define OMM_STAT_FAULT     1
`define OMM_STAT_LOST      2
`define OMM_STAT_CALINT    3
`define OMM_STAT_INITDONE  4

`define OMM_CAL_RST        16'h0000
`define OMM_ID_RST         8'h00

`endif

// *** rtl/omm_pkg.sv ***
package omm_pkg;

  typedef enum logic [2:0] {
    OMM_IDLE,
    OMM_ADDR,
    OMM_ADDR_ACK,
    OMM_WRITE,
    OMM_WRITE_ACK,
    OMM_READ,
    OMM_READ_ACK
  } omm_i2c_st_t;

  typedef struct packed {
    omm_i2c_st_t st;
    logic [7:0]  shft;
    logic [3:0]  bitCnt;
    logic        rw;
    logic        page;
    logic        ptrSet;
    logic [7:0]  ptr;
    logic        sdaLow;
    logic        sclQ;
    logic        sdaQ;
    logic        wr;
    logic [7:0]  wdata;
  } omm_i2c_t;

  typedef struct packed {
    logic        done;
  } omm_tmr_flag_t;

endpackage

// *** rtl/omm_mem_if.sv ***
`timescale 1ns/100ps
interface omm_mem_if;
  logic       page;
  logic [7:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport target (output page, output addr, output wr, output wdata, input rdata);
  modport mem    (input page, input addr, input wr, input wdata, output rdata);
endinterface

// *** rtl/omm_timer.sv ***
`timescale 1ns/100ps
module omm_timer #(
  parameter int unsigned LIMIT = 1000
) (
  input  wire logic clock,
  input  wire logic rstSync_b,
  input  wire logic run,
  output logic      done
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } omm_tmr_t;

  omm_tmr_t s;
  omm_tmr_t next_s;

  // counter saturates so a long hold never wraps and drops done
  always_comb begin
    next_s = s;
    if (!run) begin
      next_s.cnt  = '0;
      next_s.done = 1'b0;
    end else if (s.cnt != LIM) begin
      next_s.cnt = W'(s.cnt + 1'b1);
    end else begin
      next_s.done = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

  stop_clears_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    !run |=> !done) else $error("timer done while not running");
endmodule

// *** rtl/omm_i2c_target.sv ***
`timescale 1ns/100ps
`include "omm_defs.svh"
module omm_i2c_target (
  input  wire logic  clock,
  input  wire logic  rstSync_b,
  input  wire logic  scl,
  input  wire logic  sdaIn,
  output logic       sdaOut,
  output logic       sdaOe_b,
  omm_mem_if.target  mem
);
  omm_pkg::omm_i2c_t s;
  omm_pkg::omm_i2c_t next_s;
  logic              rise;
  logic              fall;
  logic              startC;
  logic              stopC;

  assign rise   = scl & ~s.sclQ;
  assign fall   = ~scl & s.sclQ;
  assign startC = s.sclQ & scl & s.sdaQ & ~sdaIn;
  assign stopC  = s.sclQ & scl & ~s.sdaQ & sdaIn;

  always_comb begin
    next_s      = s;
    next_s.wr   = 1'b0;
    next_s.sclQ = scl;
    next_s.sdaQ = sdaIn;
    if (s.wr) begin
      next_s.ptr = 8'(s.ptr + 1'b1);
    end
    if (startC) begin
      next_s.st     = omm_pkg::OMM_ADDR;
      next_s.bitCnt = '0;
      next_s.sdaLow = 1'b0;
      next_s.ptrSet = 1'b0;
    end else if (stopC) begin
      next_s.st     = omm_pkg::OMM_IDLE;
      next_s.sdaLow = 1'b0;
    end else begin
      unique case (s.st)
        omm_pkg::OMM_IDLE: begin
        end
        omm_pkg::OMM_ADDR, omm_pkg::OMM_WRITE: begin
          if (rise) begin
            next_s.shft   = {s.shft[6:0], sdaIn};
            next_s.bitCnt = 4'(s.bitCnt + 1'b1);
          end else if (fall && s.bitCnt == 4'h8) begin
            next_s.bitCnt = '0;
            if (s.st == omm_pkg::OMM_WRITE) begin
              next_s.sdaLow = 1'b1;
              next_s.st     = omm_pkg::OMM_WRITE_ACK;
              if (!s.ptrSet) begin
                next_s.ptr    = s.shft;
                next_s.ptrSet = 1'b1;
              end else begin
                next_s.wr    = 1'b1;
                next_s.wdata = s.shft;
              end
            end else if (s.shft[7:1] == `OMM_ADDR_ID || s.shft[7:1] == `OMM_ADDR_DIAG) begin
              next_s.sdaLow = 1'b1;
              next_s.rw     = s.shft[0];
              next_s.page   = (s.shft[7:1] == `OMM_ADDR_DIAG);
              next_s.st     = omm_pkg::OMM_ADDR_ACK;
            end else begin
              // another target on the bus; stay off the line until next start
              next_s.st = omm_pkg::OMM_IDLE;
            end
          end
        end
        omm_pkg::OMM_ADDR_ACK: begin
          if (fall) begin
            next_s.bitCnt = '0;
            if (s.rw) begin
              next_s.shft   = mem.rdata;
              next_s.sdaLow = ~mem.rdata[7];
              next_s.st     = omm_pkg::OMM_READ;
            end else begin
              next_s.sdaLow = 1'b0;
              next_s.st     = omm_pkg::OMM_WRITE;
            end
          end
        end
        omm_pkg::OMM_WRITE_ACK: begin
          if (fall) begin
            next_s.sdaLow = 1'b0;
            next_s.st     = omm_pkg::OMM_WRITE;
          end
        end
        omm_pkg::OMM_READ: begin
          if (rise) begin
            next_s.bitCnt = 4'(s.bitCnt + 1'b1);
          end else if (fall) begin
            if (s.bitCnt == 4'h8) begin
              next_s.sdaLow = 1'b0;
              next_s.ptr    = 8'(s.ptr + 1'b1);
              next_s.st     = omm_pkg::OMM_READ_ACK;
            end else begin
              next_s.shft   = {s.shft[6:0], 1'b0};
              next_s.sdaLow = ~s.shft[6];
            end
          end
        end
        omm_pkg::OMM_READ_ACK: begin
          if (rise) begin
            // a high ack bit from the host ends the read burst
            next_s.st = sdaIn ? omm_pkg::OMM_IDLE : omm_pkg::OMM_ADDR_ACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s      <= '0;
      s.sclQ <= 1'b1;
      s.sdaQ <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sdaOut    = 1'b0;
  assign sdaOe_b   = ~s.sdaLow;
  assign mem.page  = s.page;
  assign mem.addr  = s.ptr;
  assign mem.wr    = s.wr;
  assign mem.wdata = s.wdata;

  sequence addrMatched;
    (s.st == omm_pkg::OMM_ADDR) && fall && (s.bitCnt == 4'h8) &&
      (s.shft[7:1] == `OMM_ADDR_ID) && !startC && !stopC;
  endsequence

  start_enter_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    startC |=> (s.st == omm_pkg::OMM_ADDR) && !s.sdaLow)
    else $error("start did not enter address phase");
  addr_ack_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    addrMatched |=> s.sdaLow && (s.st == omm_pkg::OMM_ADDR_ACK))
    else $error("matching address not acknowledged");
  write_pulse_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    s.wr |=> !s.wr && (s.ptr == 8'($past(s.ptr) + 1'b1)))
    else $error("write strobe or pointer step wrong");
endmodule

// *** rtl/omm_top.sv ***
// Summary of operation
// - Identification bytes and live diagnostic readings are served over the two-wire port.
// - Diagnostics cover temperature, supply voltage, bias current, tx power and rx power.
// - Readings are reported either internally calibrated or raw with stored constants.
// - The fault pin reads low in normal operation and high while any laser fault exists.
// - The laser is on while the disable input is low, start-up is done and no fault is present or latched, and off while it is high.
// - An unconnected disable input is taken as high, so the laser stays off.
// - The presence line is held at ground at all times.
// - The serial clock is driven by the host and only sampled here.
// - The serial data line is shared and only ever pulled low by this block.
// - The signal-lost pin reads high when receive signal is gone and low otherwise.
// - The optical output goes off within 10 us of the disable input rising.
// - The optical output comes back within 1 ms of the disable input falling.
// - Start-up, including clearing any fault indication, completes within 300 ms.
`timescale 1ns/100ps
`include "omm_defs.svh"
module omm_top #(
  parameter int unsigned INIT_CYCLES = `OMM_T_INIT_CYC,
  parameter int unsigned ID_DEPTH    = `OMM_ID_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_b,
  input  wire logic        txDisable,
  input  wire logic        txDisableOpen,
  output logic             txFaultOut,
  output logic             txFaultOe_b,
  output logic             lostOut,
  output logic             lostOe_b,
  output logic             presentOut,
  output logic             presentOe_b,
  input  wire logic        laserFaultDet,
  input  wire logic        rxSignalDet,
  input  wire logic        calInternal,
  input  wire logic [15:0] tempRaw,
  input  wire logic [15:0] vccRaw,
  input  wire logic [15:0] biasRaw,
  input  wire logic [15:0] txPwrRaw,
  input  wire logic [15:0] rxPwrRaw,
  output logic             laserEnable,
  output logic             initDone
);
  localparam int NQ = `OMM_NUM_QTY;
  localparam int unsigned OFF_CYCLES   = `OMM_T_OFF_CYC;
  localparam int unsigned RESET_CYCLES = `OMM_T_RESET_CYC;
  localparam int IW = $clog2(ID_DEPTH);

  typedef struct packed {
    logic [ID_DEPTH-1:0][7:0] idMem;
    logic [NQ-1:0][15:0]      calOff;
    logic [NQ-1:0][15:0]      reading;
    logic                     faultLatch;
    logic                     laserOn;
    logic                     lost;
    logic                     txOff;
  } omm_top_t;

  ////////////////////////////////////////////////////////////////////////////////
  // reset release
  // two stages so no flop leaves reset on a release that lands near an edge
  logic [1:0] rstPipe;
  logic       rstSync_b;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // serial port and timers
  omm_mem_if memBus ();

  omm_i2c_target u_i2c (
    .clock     (clock),
    .rstSync_b (rstSync_b),
    .scl       (scl),
    .sdaIn     (sdaIn),
    .sdaOut    (sdaOut),
    .sdaOe_b   (sdaOe_b),
    .mem       (memBus.target)
  );

  omm_top_t s;
  omm_top_t next_s;
  logic     txOffEff;
  logic     disHeld;
  logic     initReached;

  assign txOffEff = txDisable | txDisableOpen;

  // start-up timer runs once after reset and then holds done high
  omm_timer #(.LIMIT(INIT_CYCLES)) u_init (
    .clock     (clock),
    .rstSync_b (rstSync_b),
    .run       (1'b1),
    .done      (initReached)
  );

  // a disable pulse held this long clears a latched fault
  omm_timer #(.LIMIT(RESET_CYCLES)) u_disrst (
    .clock     (clock),
    .rstSync_b (rstSync_b),
    .run       (s.txOff),
    .done      (disHeld)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // monitoring and laser control
  logic [NQ-1:0][15:0] rawVal;
  assign rawVal = {rxPwrRaw, txPwrRaw, biasRaw, vccRaw, tempRaw};

  // status bits from bit 0: disable, fault, lost, internal calibration, init done
  logic [7:0] statusByte;
  assign statusByte = 8'({initReached, calInternal, s.lost, s.faultLatch, s.txOff});

  always_comb begin
    int q;
    q      = 0;
    next_s = s;
    next_s.txOff = txOffEff;
    for (int i = 0; i < NQ; i++) begin
      // offsets are applied in hardware only in internal mode
      next_s.reading[i] = calInternal ? 16'(rawVal[i] + s.calOff[i]) : rawVal[i];
    end
    next_s.lost = ~rxSignalDet;
    if (laserFaultDet) begin
      next_s.faultLatch = 1'b1;
    end else if (disHeld || !initReached) begin
      next_s.faultLatch = 1'b0;
    end
    // laser follows the raw disable input so shut-off takes one cycle
    next_s.laserOn = ~txOffEff & initReached & ~s.faultLatch & ~laserFaultDet;
    if (memBus.wr) begin
      if (!memBus.page) begin
        if (memBus.addr < 8'(ID_DEPTH)) begin
          next_s.idMem[memBus.addr[IW-1:0]] = memBus.wdata;
        end
      end else if (memBus.addr >= `OMM_DIAG_CAL_BASE && memBus.addr <= `OMM_DIAG_CAL_LAST) begin
        q = int'(8'(memBus.addr - `OMM_DIAG_CAL_BASE) >> 1);
        if (memBus.addr[0]) begin
          next_s.calOff[q][7:0] = memBus.wdata;
        end else begin
          next_s.calOff[q][15:8] = memBus.wdata;
        end
      end
    end
  end

  // values are big-endian byte pairs; unmapped bytes read zero
  always_comb begin
    int q;
    q = 0;
    memBus.rdata = 8'h00;
    if (!memBus.page) begin
      if (memBus.addr < 8'(ID_DEPTH)) begin
        memBus.rdata = s.idMem[memBus.addr[IW-1:0]];
      end
    end else if (memBus.addr <= `OMM_DIAG_VAL_LAST) begin
      q = int'(memBus.addr >> 1);
      memBus.rdata = memBus.addr[0] ? s.reading[q][7:0] : s.reading[q][15:8];
    end else if (memBus.addr == `OMM_DIAG_STATUS) begin
      memBus.rdata = statusByte;
    end else if (memBus.addr >= `OMM_DIAG_CAL_BASE && memBus.addr <= `OMM_DIAG_CAL_LAST) begin
      q = int'(8'(memBus.addr - `OMM_DIAG_CAL_BASE) >> 1);
      memBus.rdata = memBus.addr[0] ? s.calOff[q][7:0] : s.calOff[q][15:8];
    end
  end

  always_ff @(posedge clock or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s       <= '0;
      s.txOff <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins: open-collector outputs drive low with enable low, release for high
  assign txFaultOut  = 1'b0;
  assign txFaultOe_b = s.faultLatch;
  assign lostOut     = 1'b0;
  assign lostOe_b    = s.lost;
  assign presentOut  = 1'b0;
  assign presentOe_b = 1'b0;
  assign laserEnable = s.laserOn;
  assign initDone    = initReached;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // antecedents that expect an input to show a clock later also sample the reset
  // copy: on the release edge the state still holds its reset values
  localparam int OFF_BOUND = 2;

  sequence disableRise;
    $rose(txOffEff);
  endsequence

  sequence cleanRelease;
    $fell(txOffEff) ##0 (initReached && !s.faultLatch && !laserFaultDet);
  endsequence

  sequence liveInt;
    rstSync_b && calInternal;
  endsequence

  sequence liveExt;
    rstSync_b && !calInternal;
  endsequence

  sequence idWrite;
    memBus.wr && !memBus.page && (memBus.addr < 8'(ID_DEPTH));
  endsequence

  sequence offsetWrite;
    memBus.wr && memBus.page && (memBus.addr == `OMM_DIAG_CAL_BASE);
  endsequence

  // shut-off is one register stage, far inside the allowed 10 us
  txoff_shut_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    disableRise |-> ##[1:OFF_BOUND] !laserEnable)
    else $error("laser not off after disable");

  txoff_hold_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    txOffEff |=> !laserEnable)
    else $error("laser on while disabled");

  open_disable_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    txDisableOpen |=> !laserEnable)
    else $error("laser on with disable input open");

  txon_restore_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    cleanRelease ##1 (initReached && !laserFaultDet && !txOffEff) |-> laserEnable)
    else $error("laser not restored after release");

  fault_pin_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    (rstSync_b && laserFaultDet) |=> txFaultOe_b && !laserEnable)
    else $error("fault not flagged on pin");

  // only a long disable pulse or start-up may clear a latched fault
  fault_hold_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    (txFaultOe_b && initReached && !disHeld) |=> txFaultOe_b)
    else $error("latched fault indication dropped");

  init_clear_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    (!initReached && !laserFaultDet) |=> !txFaultOe_b && !laserEnable)
    else $error("fault or laser active during start-up");

  laser_init_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    laserEnable |-> initReached)
    else $error("laser on before start-up finished");

  fault_reset_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    (disHeld && !laserFaultDet) |=> !txFaultOe_b)
    else $error("held disable did not clear fault");

  lost_pin_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    rstSync_b |=> (lostOe_b == !$past(rxSignalDet)))
    else $error("signal-lost pin does not follow receiver");

  present_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    !presentOe_b && !presentOut)
    else $error("presence line not grounded");

  cal_mode_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    liveInt |=> s.reading[0] == 16'($past(tempRaw) + $past(s.calOff[0])))
    else $error("internal calibration not applied");

  offset_write_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    offsetWrite |=> s.calOff[0][15:8] == $past(memBus.wdata))
    else $error("calibration offset not stored");

  raw_mode_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    liveExt |=> s.reading[4] == $past(rxPwrRaw))
    else $error("raw reading not reported");

  // external mode hands the supply, bias and tx power readings over untouched
  raw_vcc_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    liveExt |=> s.reading[1] == $past(vccRaw))
    else $error("supply reading not reported");

  raw_bias_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    liveExt |=> s.reading[2] == $past(biasRaw))
    else $error("bias reading not reported");

  raw_txpwr_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    liveExt |=> s.reading[3] == $past(txPwrRaw))
    else $error("transmit power reading not reported");

  // a write is registered on the strobe edge, at the pointer the strobe carried
  id_write_a: assert property (@(posedge clock) disable iff (!rstSync_b)
    idWrite |=> s.idMem[$past(memBus.addr[IW-1:0])] == $past(memBus.wdata))
    else $error("identification byte not stored");
endmodule

// *** verification/omm_host_model.sv ***
`timescale 1ns/100ps
module omm_host_model #(
  parameter int QUARTER = 63
) (
  input  wire logic clock,
  input  wire logic sdaWire,
  output logic      scl,
  output logic      sdaDrv
);
  // four quarters of 63 clocks make a 2.52 us bit, just under 400 kHz

  initial begin
    scl    = 1'b1;
    sdaDrv = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic quarter();
    repeat (QUARTER) @(negedge clock);
  endtask

  // the clock is only ever driven here and stands high between frames
  task automatic start_cond();
    sdaDrv = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sdaDrv = 1'b0;
    quarter();
    scl = 1'b0;
    quarter();
  endtask

  task automatic stop_cond();
    sdaDrv = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    sdaDrv = 1'b1;
    quarter();
  endtask

  // data moves only mid-low so it can never be taken for a start or stop
  task automatic put_bit(input logic b);
    sdaDrv = b;
    quarter();
    scl = 1'b1;
    quarter();
    quarter();
    scl = 1'b0;
    quarter();
  endtask

  // releasing lets the pull-up win unless the target holds the wire low
  task automatic get_bit(output logic b);
    sdaDrv = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    b = sdaWire;
    quarter();
    scl = 1'b0;
    quarter();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic bitVal;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(bitVal);
    ack = ~bitVal;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask
endmodule

// *** verification/test_optical_module_mgmt_status.sv ***
`timescale 1ns/100ps
`define CHECK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_optical_module_mgmt_status;
  localparam int INIT_CYC  = 50;
  localparam int FAULT_CLR = 1000;

  logic        clock;
  logic        rst_b         = 1'b0;
  logic        txDisable     = 1'b0;
  logic        txDisableOpen = 1'b0;
  logic        laserFaultDet = 1'b0;
  logic        rxSignalDet   = 1'b1;
  logic        calInternal   = 1'b0;
  logic [15:0] tempRaw       = 16'hFFF0;
  logic [15:0] vccRaw        = 16'h8421;
  logic [15:0] biasRaw       = 16'h0C35;
  logic [15:0] txPwrRaw      = 16'h7E01;
  logic [15:0] rxPwrRaw      = 16'h1A2B;
  logic        sdaOut;
  logic        sdaOe_b;
  logic        txFaultOut;
  logic        txFaultOe_b;
  logic        lostOut;
  logic        lostOe_b;
  logic        presentOut;
  logic        presentOe_b;
  logic        laserEnable;
  logic        initDone;
  logic        scl;
  logic        sdaDrv;
  logic        sdaWire;
  logic        txFaultPin;
  logic        lostPin;
  logic        presentPin;
  logic        nack;
  logic [79:0] raws;
  logic [7:0]  expBuf [0:15];
  int          mismatches    = 0;
  int          checks        = 0;
  int          waited;

  // open-drain pins with host pull-ups
  assign sdaWire    = sdaDrv & (sdaOe_b | sdaOut);
  assign txFaultPin = txFaultOe_b | txFaultOut;
  assign lostPin    = lostOe_b | lostOut;
  assign presentPin = presentOe_b | presentOut;
  assign raws       = {tempRaw, vccRaw, biasRaw, txPwrRaw, rxPwrRaw};

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  omm_top #(.INIT_CYCLES(INIT_CYC)) omm_top_inst (
    .clock(clock), .rst_b(rst_b), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe_b(sdaOe_b), .txDisable(txDisable), .txDisableOpen(txDisableOpen),
    .txFaultOut(txFaultOut), .txFaultOe_b(txFaultOe_b), .lostOut(lostOut),
    .lostOe_b(lostOe_b), .presentOut(presentOut), .presentOe_b(presentOe_b),
    .laserFaultDet(laserFaultDet), .rxSignalDet(rxSignalDet), .calInternal(calInternal),
    .tempRaw(tempRaw), .vccRaw(vccRaw), .biasRaw(biasRaw), .txPwrRaw(txPwrRaw),
    .rxPwrRaw(rxPwrRaw), .laserEnable(laserEnable), .initDone(initDone)
  );

  omm_host_model omm_host_model_inst (
    .clock(clock), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic test_done(input string name);
    $display("test %s finished, %0d checks so far", name, checks);
  endtask

  task automatic put_ack(input logic [7:0] b);
    logic ack;
    omm_host_model_inst.send_byte(b, ack);
    `CHECK(ack, 1'b1);
  endtask

  task automatic open_write(input logic [6:0] dev, input logic [7:0] ptr);
    omm_host_model_inst.start_cond();
    put_ack({dev, 1'b0});
    put_ack(ptr);
  endtask

  task automatic dev_write8(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    open_write(dev, ptr);
    put_ack(d);
    omm_host_model_inst.stop_cond();
  endtask

  task automatic dev_write16(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [15:0] d);
    open_write(dev, ptr);
    put_ack(d[15:8]);
    put_ack(d[7:0]);
    omm_host_model_inst.stop_cond();
  endtask

  // sets the pointer, then reads n bytes against expBuf with a repeated start
  task automatic dev_read(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    logic [7:0] got;
    open_write(dev, ptr);
    omm_host_model_inst.start_cond();
    put_ack({dev, 1'b1});
    for (int i = 0; i < n; i++) begin
      omm_host_model_inst.recv_byte(i == n - 1, got);
      `CHECK(got, expBuf[i]);
    end
    omm_host_model_inst.stop_cond();
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clock);
    `CHECK(sdaOe_b, 1'b1);
    `CHECK(presentPin, 1'b0);
    `CHECK(laserEnable, 1'b0);
    rst_b = 1'b1;
    tick(10);
    `CHECK(initDone, 1'b0);
    `CHECK(laserEnable, 1'b0);
    for (waited = 10; waited < 100 && initDone !== 1'b1; waited++) tick(1);
    `CHECK(initDone, 1'b1);
    `CHECK(waited >= INIT_CYC, 1'b1);
    tick(2);
    `CHECK(laserEnable, 1'b1);
    `CHECK(txFaultPin, 1'b0);
    `CHECK(lostPin, 1'b0);
    `CHECK(presentPin, 1'b0);
    test_done("startup");

    txDisable = 1'b1;
    tick(1);
    `CHECK(laserEnable, 1'b0);
    txDisable = 1'b0;
    tick(1);
    `CHECK(laserEnable, 1'b1);
    txDisableOpen = 1'b1;
    tick(1);
    `CHECK(laserEnable, 1'b0);
    txDisableOpen = 1'b0;
    tick(1);
    `CHECK(laserEnable, 1'b1);
    rxSignalDet = 1'b0;
    tick(1);
    `CHECK(lostPin, 1'b1);
    rxSignalDet = 1'b1;
    tick(1);
    `CHECK(lostPin, 1'b0);
    test_done("pins");

    laserFaultDet = 1'b1;
    tick(1);
    `CHECK(txFaultPin, 1'b1);
    laserFaultDet = 1'b0;
    tick(3);
    `CHECK(txFaultPin, 1'b1);
    `CHECK(laserEnable, 1'b0);
    // a disable pulse shorter than the reset time must not clear the latch
    txDisable = 1'b1;
    tick(FAULT_CLR / 2);
    txDisable = 1'b0;
    tick(2);
    `CHECK(txFaultPin, 1'b1);
    txDisable = 1'b1;
    tick(FAULT_CLR + 5);
    txDisable = 1'b0;
    tick(2);
    `CHECK(txFaultPin, 1'b0);
    `CHECK(laserEnable, 1'b1);
    test_done("fault");

    dev_write8(7'h50, 8'h0F, 8'hA5);
    expBuf[0] = 8'hA5;
    expBuf[1] = 8'h00;
    dev_read(7'h50, 8'h0F, 2);
    test_done("id page");

    for (int i = 0; i < 10; i++) expBuf[i] = raws[79 - 8 * i -: 8];
    expBuf[10] = 8'h10;
    dev_read(7'h51, 8'h00, 11);
    dev_write16(7'h51, 8'h10, 16'h0111);
    calInternal = 1'b1;
    // offset addition wraps modulo 2^16
    expBuf[0] = 8'h01;
    expBuf[1] = 8'h01;
    dev_read(7'h51, 8'h00, 2);
    test_done("diagnostics");

    omm_host_model_inst.start_cond();
    omm_host_model_inst.send_byte({7'h52, 1'b0}, nack);
    `CHECK(nack, 1'b0);
    omm_host_model_inst.stop_cond();
    test_done("foreign address");
    final_report();
  end

  // the serial traffic needs about 80k clocks
  initial begin
    repeat (120000) @(posedge clock);
    mismatches++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    final_report();
  end
endmodule
